// file: design/remote_radio_port.sv
// Remote radio port sequencer: id filter, RTS/CTS, retries, bid scheduler, pause
//
// What this block does
// - Accept only messages whose net_identifier equals the configured 8-bit id.
// - After raising RTS wait at least the CTS delay in 10 ms ticks.
// - After sending, wait the response timeout, then retransmit if no reply.
// - The same response timeout bounds the wait for a reply to a bid.
// - After a bid's response timeout wait the bid interval before the next bid.
// - During the bid interval queued normal messages are transmitted.
// - Retry up to the retry count, then report error; a slave never retries.
// - Count messages and bids; after the message count insert the pause time.
// - Settings 1..99 bid that address once; 100 bids address 00 once.
// - Settings 100..199 bid downward from setting minus 100, ending after 00.
// - In that mode the stored setting follows each decremented address.
// - Only a master bids; a pending bid beats normal messages, which go in the next interval.
// - Settings 200..299 bid one address repeatedly with timeout then interval.
// - Settings 300..399 bid downward to 00 then restart, forever.
// - In cyclic mode the stored setting keeps its 300-range value.
`timescale 1ns/100ps
`default_nettype none
module remote_radio_port #(
	parameter int TICK_CYCLES = radio_bid_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic rts,
	input wire logic cts_pin,
	output radio_bid_pkg::tx_s tx,
	input wire logic tx_done,
	input wire radio_bid_pkg::rx_s rx,
	output logic rx_accept,
	input wire logic msg_req,
	input wire logic [6:0] msg_addr,
	output logic msg_ok,
	output logic msg_fail,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		radio_bid_pkg::fsm_e st;
		logic cts_s1;
		logic cts_s2;
		logic [21:0] pre;
		logic [16:0] tmr;
		logic [16:0] ivt;
		logic [15:0] cts_cfg;
		logic [15:0] resp_cfg;
		logic [15:0] bidint_cfg;
		logic [15:0] retry_cfg;
		logic [15:0] pause_cfg;
		logic [15:0] msgcnt_cfg;
		logic [15:0] sent;
		logic [15:0] retry;
		logic [7:0] netid;
		logic master;
		logic [8:0] bid_set;
		logic [6:0] bid_cur;
		logic [6:0] bid_start;
		logic seq_on;
		logic bid_pend;
		logic is_bid;
		logic [3:0] sts;
		logic [3:0] ien;
		logic rts;
		radio_bid_pkg::tx_s tx;
		logic rx_accept;
		logic msg_ok;
		logic msg_fail;
		logic [31:0] prdata;
		logic perr;
	} state_s;

	state_s r;
	state_s n;
	logic tick;
	logic tmr_done;
	logic reply_ok;
	logic req_live;
	logic pause_due;
	logic [15:0] eff_retry;
	logic [3:0] ev;
	logic wr;
	logic [11:0] wa;

	assign tick = (r.pre == 22'(TICK_CYCLES - 1));
	assign tmr_done = (r.tmr == 17'h00000);
	assign reply_ok = rx.valid && rx.reply && (rx.net_id == r.netid);
	// Request still up during its own ok or fail pulse is already served
	assign req_live = msg_req && !r.msg_ok && !r.msg_fail;
	assign pause_due = (r.msgcnt_cfg != 16'h0000) && (r.sent >= r.msgcnt_cfg);
	assign eff_retry = r.master ? r.retry_cfg : 16'h0000;
	assign wr = psel && penable && pwrite;
	assign wa = paddr;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		n = r;
		ev = 4'h0;
		n.tx.start = 1'b0;
		n.rx_accept = 1'b0;
		n.msg_ok = 1'b0;
		n.msg_fail = 1'b0;
		// Pin synchroniser and 10 ms prescaler
		n.cts_s1 = cts_pin;
		n.cts_s2 = r.cts_s1;
		n.pre = tick ? 22'h000000 : r.pre + 22'h000001;
		if (tick && !tmr_done) begin
			n.tmr = r.tmr - 17'h00001;
		end
		// Net_identifier filter on every received frame
		if (rx.valid) begin
			if (rx.net_id == r.netid) begin
				n.rx_accept = 1'b1;
			end else begin
				ev[radio_bid_pkg::EV_FOREIGN] = 1'b1;
			end
		end
		// Sequencer
		case (r.st)
			radio_bid_pkg::ST_IDLE: begin
				n.rts = 1'b0;
				if (r.master && r.bid_pend) begin
					n.bid_pend = 1'b0;
					n.is_bid = 1'b1;
					n.tx.addr = r.bid_cur;
					n.st = pause_due ? radio_bid_pkg::ST_PAUSE : radio_bid_pkg::ST_RTS;
				end else if (req_live) begin
					n.is_bid = 1'b0;
					n.retry = 16'h0000;
					n.tx.addr = msg_addr;
					n.st = pause_due ? radio_bid_pkg::ST_PAUSE : radio_bid_pkg::ST_RTS;
				end
				n.tmr = pause_due ? {1'b0, r.pause_cfg} + 17'h00001
					: {1'b0, r.cts_cfg} + 17'h00001;
			end
			radio_bid_pkg::ST_PAUSE: begin
				n.rts = 1'b0;
				if (tmr_done) begin
					n.sent = 16'h0000;
					n.tmr = {1'b0, r.cts_cfg} + 17'h00001;
					n.st = radio_bid_pkg::ST_RTS;
				end
			end
			radio_bid_pkg::ST_RTS: begin
				n.rts = 1'b1;
				if (tmr_done && r.cts_s2) begin
					n.tx.start = 1'b1;
					n.tx.bid = r.is_bid;
					n.st = radio_bid_pkg::ST_SEND;
				end
			end
			radio_bid_pkg::ST_SEND: begin
				n.rts = 1'b1;
				if (tx_done) begin
					n.rts = 1'b0;
					if (r.sent != 16'hffff) begin
						n.sent = r.sent + 16'h0001;
					end
					n.tmr = {1'b0, r.resp_cfg} + 17'h00001;
					n.st = radio_bid_pkg::ST_RESP;
				end
			end
			radio_bid_pkg::ST_RESP: begin
				n.rts = 1'b0;
				if (r.is_bid) begin
					// A bid always waits out the full timeout
					if (tmr_done) begin
						n.ivt = {1'b0, r.bidint_cfg};
						n.st = radio_bid_pkg::ST_INTV;
					end
				end else if (reply_ok) begin
					n.msg_ok = 1'b1;
					ev[radio_bid_pkg::EV_MSG_OK] = 1'b1;
					n.st = r.seq_on ? radio_bid_pkg::ST_INTV : radio_bid_pkg::ST_IDLE;
				end else if (tmr_done) begin
					if (r.retry < eff_retry) begin
						n.retry = r.retry + 16'h0001;
						n.tmr = {1'b0, r.cts_cfg} + 17'h00001;
						n.st = radio_bid_pkg::ST_RTS;
					end else begin
						n.msg_fail = 1'b1;
						ev[radio_bid_pkg::EV_MSG_FAIL] = 1'b1;
						n.st = r.seq_on ? radio_bid_pkg::ST_INTV : radio_bid_pkg::ST_IDLE;
					end
				end
			end
			radio_bid_pkg::ST_INTV: begin
				n.rts = 1'b0;
				if (tick && r.ivt != 17'h00000) begin
					n.ivt = r.ivt - 17'h00001;
				end
				if (req_live) begin
					// Queued messages go first, interval count is kept
					n.is_bid = 1'b0;
					n.retry = 16'h0000;
					n.tx.addr = msg_addr;
					n.tmr = pause_due ? {1'b0, r.pause_cfg} + 17'h00001
						: {1'b0, r.cts_cfg} + 17'h00001;
					n.st = pause_due ? radio_bid_pkg::ST_PAUSE : radio_bid_pkg::ST_RTS;
				end else if (r.ivt == 17'h00000 || !r.seq_on) begin
					n.st = radio_bid_pkg::ST_IDLE;
					if (r.seq_on) begin
						n.bid_pend = 1'b1;
						if (r.bid_set < radio_bid_pkg::BID_DEC_LO) begin
							n.seq_on = 1'b0;
							n.bid_pend = 1'b0;
							ev[radio_bid_pkg::EV_BID_END] = 1'b1;
						end else if (r.bid_set == radio_bid_pkg::BID_DEC_LO) begin
							n.seq_on = 1'b0;
							n.bid_pend = 1'b0;
							ev[radio_bid_pkg::EV_BID_END] = 1'b1;
						end else if (r.bid_set < radio_bid_pkg::BID_CONT_LO) begin
							n.bid_cur = r.bid_cur - 7'h01;
							n.bid_set = r.bid_set - 9'h001;
						end else if (r.bid_set < radio_bid_pkg::BID_CYC_LO) begin
							n.bid_cur = r.bid_cur;
						end else begin
							// Setting is left alone so it survives a restart
							n.bid_cur = (r.bid_cur == 7'h00) ? r.bid_start
								: r.bid_cur - 7'h01;
						end
					end
				end
			end
			default: begin
				n.st = radio_bid_pkg::ST_IDLE;
			end
		endcase
		// APB setup phase: decode and capture read data
		if (psel && !penable) begin
			n.perr = 1'b0;
			n.prdata = 32'h00000000;
			if (wa == radio_bid_pkg::OFS_CTRL) begin
				n.prdata = {31'h00000000, r.master};
			end else if (wa == radio_bid_pkg::OFS_NETID) begin
				n.prdata = {24'h000000, r.netid};
			end else if (wa == radio_bid_pkg::OFS_CTS) begin
				n.prdata = {16'h0000, r.cts_cfg};
			end else if (wa == radio_bid_pkg::OFS_RESP) begin
				n.prdata = {16'h0000, r.resp_cfg};
			end else if (wa == radio_bid_pkg::OFS_BIDINT) begin
				n.prdata = {16'h0000, r.bidint_cfg};
			end else if (wa == radio_bid_pkg::OFS_RETRY) begin
				n.prdata = {16'h0000, r.retry_cfg};
			end else if (wa == radio_bid_pkg::OFS_PAUSE) begin
				n.prdata = {16'h0000, r.pause_cfg};
			end else if (wa == radio_bid_pkg::OFS_MSGCNT) begin
				n.prdata = {16'h0000, r.msgcnt_cfg};
			end else if (wa == radio_bid_pkg::OFS_BIDADDR) begin
				n.prdata = {23'h000000, r.bid_set};
			end else if (wa == radio_bid_pkg::OFS_STATUS) begin
				n.prdata = {28'h0000000, r.sts};
			end else if (wa == radio_bid_pkg::OFS_CLEAR) begin
				n.prdata = 32'h00000000;
			end else if (wa == radio_bid_pkg::OFS_IRQEN) begin
				n.prdata = {28'h0000000, r.ien};
			end else if (wa == radio_bid_pkg::OFS_STATE) begin
				n.prdata = {r.retry, r.seq_on, r.bid_cur, 5'h00, r.st};
			end else begin
				n.perr = 1'b1;
			end
		end
		// APB access phase: writes take effect here
		n.sts = r.sts;
		if (wr && !r.perr) begin
			if (wa == radio_bid_pkg::OFS_CTRL) begin
				n.master = pwdata[radio_bid_pkg::CTRL_MASTER_BIT];
			end else if (wa == radio_bid_pkg::OFS_NETID) begin
				n.netid = pwdata[7:0];
			end else if (wa == radio_bid_pkg::OFS_CTS) begin
				n.cts_cfg = pwdata[15:0];
			end else if (wa == radio_bid_pkg::OFS_RESP) begin
				n.resp_cfg = pwdata[15:0];
			end else if (wa == radio_bid_pkg::OFS_BIDINT) begin
				n.bidint_cfg = pwdata[15:0];
			end else if (wa == radio_bid_pkg::OFS_RETRY) begin
				n.retry_cfg = pwdata[15:0];
			end else if (wa == radio_bid_pkg::OFS_PAUSE) begin
				n.pause_cfg = pwdata[15:0];
			end else if (wa == radio_bid_pkg::OFS_MSGCNT) begin
				n.msgcnt_cfg = pwdata[15:0];
			end else if (wa == radio_bid_pkg::OFS_BIDADDR) begin
				// New setting restarts the bid scheduler
				n.bid_set = pwdata[8:0];
				n.seq_on = (pwdata[8:0] >= radio_bid_pkg::BID_ONE_LO)
					&& (pwdata[8:0] < radio_bid_pkg::BID_TOP);
				n.bid_pend = n.seq_on;
				if (pwdata[8:0] < radio_bid_pkg::BID_DEC_LO) begin
					n.bid_cur = pwdata[6:0];
				end else if (pwdata[8:0] < radio_bid_pkg::BID_CONT_LO) begin
					n.bid_cur = 7'(pwdata[8:0] - radio_bid_pkg::BID_DEC_LO);
				end else if (pwdata[8:0] < radio_bid_pkg::BID_CYC_LO) begin
					n.bid_cur = 7'(pwdata[8:0] - radio_bid_pkg::BID_CONT_LO);
				end else begin
					n.bid_cur = 7'(pwdata[8:0] - radio_bid_pkg::BID_CYC_LO);
				end
				n.bid_start = n.bid_cur;
			end else if (wa == radio_bid_pkg::OFS_CLEAR) begin
				n.sts = r.sts & ~pwdata[3:0];
			end else if (wa == radio_bid_pkg::OFS_IRQEN) begin
				n.ien = pwdata[3:0];
			end
		end
		// Events set after the clear so a same-cycle event is kept
		n.sts = n.sts | ev;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '{st: radio_bid_pkg::ST_IDLE, master: radio_bid_pkg::RST_MASTER,
				netid: radio_bid_pkg::RST_NETID, cts_cfg: radio_bid_pkg::RST_CFG16,
				resp_cfg: radio_bid_pkg::RST_CFG16, bidint_cfg: radio_bid_pkg::RST_CFG16,
				retry_cfg: radio_bid_pkg::RST_CFG16, pause_cfg: radio_bid_pkg::RST_CFG16,
				msgcnt_cfg: radio_bid_pkg::RST_CFG16, bid_set: radio_bid_pkg::RST_BIDSET,
				default: '0};
		end else begin
			r <= n;
		end
	end

	// Outputs
	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && r.perr;
	assign rts = r.rts;
	assign tx = r.tx;
	assign rx_accept = r.rx_accept;
	assign msg_ok = r.msg_ok;
	assign msg_fail = r.msg_fail;
	assign irq = |(r.sts & r.ien);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	AST_NETID_TAKE: assert property (@(posedge mclk) disable iff (!reset_n)
		rx.valid && rx.net_id == r.netid |=> rx_accept)
		else $error("matching frame not accepted");
	AST_NETID_DROP: assert property (@(posedge mclk) disable iff (!reset_n)
		rx.valid && rx.net_id != r.netid |=> !rx_accept && r.sts[radio_bid_pkg::EV_FOREIGN])
		else $error("foreign frame accepted");
	AST_CTS_WAIT: assert property (@(posedge mclk) disable iff (!reset_n)
		tx.start |-> $past(r.cts_s2) && $past(tmr_done) && rts)
		else $error("send started before cts delay and cts");
	AST_RESP_RETRY: assert property (@(posedge mclk) disable iff (!reset_n)
		r.st == radio_bid_pkg::ST_RESP && !r.is_bid && tmr_done && !reply_ok
		&& r.retry < eff_retry |=> r.st == radio_bid_pkg::ST_RTS && r.retry == $past(r.retry) + 16'h0001)
		else $error("no retransmit after timeout");
	AST_BID_TIMEOUT: assert property (@(posedge mclk) disable iff (!reset_n)
		r.st == radio_bid_pkg::ST_RESP && r.is_bid && !tmr_done |=> r.st == radio_bid_pkg::ST_RESP)
		else $error("bid wait ended early");
	AST_INTV_MSG: assert property (@(posedge mclk) disable iff (!reset_n)
		r.st == radio_bid_pkg::ST_INTV && req_live |=> !r.is_bid && r.st != radio_bid_pkg::ST_INTV)
		else $error("queued message not sent in interval");
	AST_FAIL_COUNT: assert property (@(posedge mclk) disable iff (!reset_n)
		msg_fail |-> $past(r.retry) == $past(eff_retry) && r.sts[radio_bid_pkg::EV_MSG_FAIL])
		else $error("error reported before retries used");
	AST_PAUSE_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
		r.st == radio_bid_pkg::ST_PAUSE |-> r.msgcnt_cfg != 16'h0000)
		else $error("pause with message count zero");
	AST_DEC_TRACK: assert property (@(posedge mclk) disable iff (!reset_n)
		r.st == radio_bid_pkg::ST_INTV && r.ivt == 17'h00000 && r.seq_on && !req_live && !wr
		&& r.bid_set > radio_bid_pkg::BID_DEC_LO && r.bid_set < radio_bid_pkg::BID_CONT_LO
		|=> r.bid_set == $past(r.bid_set) - 9'h001 && r.bid_cur == $past(r.bid_cur) - 7'h01)
		else $error("decrementing setting not tracked");
	AST_CYC_KEEP: assert property (@(posedge mclk) disable iff (!reset_n)
		r.bid_set >= radio_bid_pkg::BID_CYC_LO && !wr |=> r.bid_set == $past(r.bid_set))
		else $error("cyclic setting changed");
	COV_RETRY_FAIL: cover property (@(posedge mclk) disable iff (!reset_n) msg_fail);
	COV_PAUSE: cover property (@(posedge mclk) disable iff (!reset_n)
		r.st == radio_bid_pkg::ST_PAUSE);
	COV_CYC_WRAP: cover property (@(posedge mclk) disable iff (!reset_n)
		r.seq_on && r.bid_cur == 7'h00 ##[1:1000] r.bid_cur == r.bid_start && r.bid_start != 7'h00);
endmodule : remote_radio_port
`default_nettype wire

// file: design/radio_bid_pkg.sv
// Constants, types and register map of the radio network bid sequencer
`default_nettype none
package radio_bid_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_NETID = 12'h004;
	localparam logic [11:0] OFS_CTS = 12'h008;
	localparam logic [11:0] OFS_RESP = 12'h00c;
	localparam logic [11:0] OFS_BIDINT = 12'h010;
	localparam logic [11:0] OFS_RETRY = 12'h014;
	localparam logic [11:0] OFS_PAUSE = 12'h018;
	localparam logic [11:0] OFS_MSGCNT = 12'h01c;
	localparam logic [11:0] OFS_BIDADDR = 12'h020;
	localparam logic [11:0] OFS_STATUS = 12'h024;
	localparam logic [11:0] OFS_CLEAR = 12'h028;
	localparam logic [11:0] OFS_IRQEN = 12'h02c;
	localparam logic [11:0] OFS_STATE = 12'h030;
	// Field positions
	localparam int CTRL_MASTER_BIT = 0;
	localparam int EV_MSG_OK = 0;
	localparam int EV_MSG_FAIL = 1;
	localparam int EV_BID_END = 2;
	localparam int EV_FOREIGN = 3;
	// Reset values
	localparam logic [15:0] RST_CFG16 = 16'h0000;
	localparam logic [7:0] RST_NETID = 8'h00;
	localparam logic RST_MASTER = 1'b1;
	localparam logic [8:0] RST_BIDSET = 9'h000;
	// Bid setting range bounds
	localparam logic [8:0] BID_ONE_LO = 9'd1;
	localparam logic [8:0] BID_DEC_LO = 9'd100;
	localparam logic [8:0] BID_CONT_LO = 9'd200;
	localparam logic [8:0] BID_CYC_LO = 9'd300;
	localparam logic [8:0] BID_TOP = 9'd400;
	// Timing: 10 ms tick from a 250 MHz clock
	localparam int TICK_MS = 10;
	localparam int CLK_KHZ = 250000;
	localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
	// Sequencer states, Gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RTS = 3'b001,
		ST_SEND = 3'b011,
		ST_RESP = 3'b010,
		ST_INTV = 3'b110,
		ST_PAUSE = 3'b111
	} fsm_e;
	// Receive bundle from the modem
	typedef struct packed {
		logic valid;
		logic [7:0] net_id;
		logic reply;
	} rx_s;
	// Transmit request to the modem
	typedef struct packed {
		logic start;
		logic bid;
		logic [6:0] addr;
	} tx_s;
endpackage : radio_bid_pkg
`default_nettype wire

// file: testbench/modem_model.sv
// Behavioural radio modem with the remote slave stations behind it
`timescale 1ns/100ps
`default_nettype none
module modem_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic rts,
	input wire radio_bid_pkg::tx_s tx,
	input wire logic [3:0] lag,
	input wire logic reply_on,
	input wire logic [7:0] reply_id,
	output logic cts_pin,
	output logic tx_done,
	output radio_bid_pkg::rx_s rx
);
	logic [1:0] ph;
	logic [3:0] n;
	////////////////////////////////////////////////////////////////////////////////
	// Sends the frame, then answers after lag cycles; idle receive lines keep toggling
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ph <= 2'd0;
			n <= 4'h0;
			cts_pin <= 1'b0;
			tx_done <= 1'b0;
			rx <= '0;
		end else begin
			cts_pin <= rts;
			tx_done <= 1'b0;
			rx.valid <= 1'b0;
			rx.net_id <= ~rx.net_id;
			rx.reply <= ~rx.reply;
			if (n != 4'h0) begin
				n <= n - 4'h1;
			end else if (ph == 2'd0 && tx.start) begin
				ph <= 2'd1;
				n <= lag;
			end else if (ph == 2'd1) begin
				tx_done <= 1'b1;
				ph <= reply_on ? 2'd2 : 2'd0;
				n <= lag;
			end else if (ph == 2'd2) begin
				rx <= {1'b1, reply_id, 1'b1}; // Answer well inside the timeout
				ph <= 2'd0;
			end
		end
	end
endmodule : modem_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the remote radio port sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int TK = 4;
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, rts, cts_pin, tx_done;
	logic rx_accept, msg_req, msg_ok, msg_fail, irq, reply_on, er, rts_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0] msg_addr;
	logic [7:0] reply_id;
	logic [3:0] lag;
	radio_bid_pkg::tx_s tx;
	radio_bid_pkg::rx_s rx;
	logic [7:0] sq[$];
	int tq[$];
	int n_errors, checks_done, cyc, t_rts, n_st, n_acc, n_ok, n_fail, k0;

	remote_radio_port #(.TICK_CYCLES(TK)) u_remote_radio_port (.mclk(mclk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rts(rts), .cts_pin(cts_pin),
		.tx(tx), .tx_done(tx_done), .rx(rx), .rx_accept(rx_accept), .msg_req(msg_req),
		.msg_addr(msg_addr), .msg_ok(msg_ok), .msg_fail(msg_fail), .irq(irq));
	modem_model u_modem_model (.mclk(mclk), .reset_n(reset_n), .rts(rts), .tx(tx), .lag(lag),
		.reply_on(reply_on), .reply_id(reply_id), .cts_pin(cts_pin), .tx_done(tx_done), .rx(rx));
	////////////////////////////////////////////////////////////////////////////////
	// Logs frames and counts pulses where outputs are settled
	always @(negedge mclk) begin
		cyc++;
		if (rts === 1'b1 && rts_q !== 1'b1) t_rts = cyc;
		rts_q = rts;
		if (tx.start === 1'b1) begin
			sq.push_back({tx.bid, tx.addr});
			tq.push_back(cyc);
			n_st++;
		end
		if (rx_accept === 1'b1) n_acc++;
		if (msg_ok === 1'b1) n_ok++;
		if (msg_fail === 1'b1) n_fail++;
	end
	// Originating device drops its request once it sees msg_ok or msg_fail
	always @(posedge mclk) if (msg_ok === 1'b1 || msg_fail === 1'b1) msg_req <= 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	task complete_run;
		if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wait_for(ref int c, input int n);
		int k;
		for (k = 0; k < 20000 && c < n; k++) @(posedge mclk);
		if (c < n) begin
			n_errors++;
			complete_run();
		end
	endtask : wait_for
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 100) begin
			n_errors++;
			complete_run();
		end
	endtask : apb
	task automatic send_msg(input logic [6:0] a);
		repeat (2) @(posedge mclk);
		msg_addr <= a;
		msg_req <= 1'b1;
		wait_for(n_ok, n_ok + 1);
	endtask : send_msg
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		apb(1'b0, radio_bid_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", {31'h0, radio_bid_pkg::RST_MASTER}, rd);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, radio_bid_pkg::OFS_NETID, 32'h5a);
		apb(1'b0, radio_bid_pkg::OFS_NETID, 32'h0);
		chk("netid", 32'h5a, rd);
		apb(1'b1, radio_bid_pkg::OFS_CTS, 32'h2);
		apb(1'b1, radio_bid_pkg::OFS_RESP, 32'ha);
		apb(1'b1, radio_bid_pkg::OFS_BIDINT, 32'h2);
		apb(1'b1, radio_bid_pkg::OFS_RETRY, 32'h2);
		apb(1'b1, radio_bid_pkg::OFS_IRQEN, 32'h7);
	endtask : t_regs
	task t_msg_ok;
		k0 = n_st;
		send_msg(7'h15);
		chk("frame", {1'b0, 7'h15}, sq[k0]);
		chk("cts wait", 32'h1, 32'(tq[k0] - t_rts >= 2 * TK));
		chk("accepts", 32'h1, n_acc);
		@(negedge mclk);
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'b1, radio_bid_pkg::OFS_CLEAR, 32'hf);
		@(negedge mclk);
		chk("irq clear", 32'h0, {31'h0, irq});
	endtask : t_msg_ok
	task t_fail(input logic m, input int tries);
		apb(1'b1, radio_bid_pkg::OFS_CTRL, {31'h0, m});
		reply_id <= 8'ha5;
		k0 = n_st;
		msg_req <= 1'b1;
		wait_for(n_fail, n_fail + 1);
		chk("sends", tries, n_st - k0);
		chk("accepts", 32'h1, n_acc);
		apb(1'b0, radio_bid_pkg::OFS_STATUS, 32'h0);
		chk("status", 32'ha, rd);
		apb(1'b1, radio_bid_pkg::OFS_CLEAR, 32'hf);
		apb(1'b1, radio_bid_pkg::OFS_CTRL, 32'h1);
		reply_id <= 8'h5a;
	endtask : t_fail
	task t_bid_dec;
		k0 = n_st;
		apb(1'b1, radio_bid_pkg::OFS_BIDADDR, 32'd102);
		wait_for(n_st, k0 + 1);
		msg_addr <= 7'h33;
		msg_req <= 1'b1;
		wait_for(n_st, k0 + 4);
		chk("bid 2", {1'b1, 7'h2}, sq[k0]);
		chk("queued msg", {1'b0, 7'h33}, sq[k0 + 1]);
		chk("bid 1", {1'b1, 7'h1}, sq[k0 + 2]);
		chk("bid 0", {1'b1, 7'h0}, sq[k0 + 3]);
		chk("bid gap", 32'h1, 32'(tq[k0 + 2] - tq[k0] >= 12 * TK));
		apb(1'b0, radio_bid_pkg::OFS_BIDADDR, 32'h0);
		chk("setting", 32'd100, rd);
		repeat (20 * TK) @(posedge mclk);
		apb(1'b0, radio_bid_pkg::OFS_STATUS, 32'h0);
		chk("bid end", 32'h5, rd);
		chk("no more bids", k0 + 4, n_st);
		apb(1'b1, radio_bid_pkg::OFS_CLEAR, 32'hf);
	endtask : t_bid_dec
	task t_bid(input logic [8:0] s, input logic [6:0] a0, input logic [6:0] a1);
		k0 = n_st;
		apb(1'b1, radio_bid_pkg::OFS_BIDADDR, {23'h0, s});
		wait_for(n_st, k0 + 3);
		apb(1'b0, radio_bid_pkg::OFS_BIDADDR, 32'h0);
		chk("setting", {23'h0, s}, rd);
		apb(1'b1, radio_bid_pkg::OFS_BIDADDR, 32'h0);
		chk("bid a", {1'b1, a0}, sq[k0]);
		chk("bid b", {1'b1, a1}, sq[k0 + 1]);
		chk("bid c", {1'b1, a0}, sq[k0 + 2]);
		repeat (20 * TK) @(posedge mclk);
	endtask : t_bid
	task t_single(input logic [8:0] s, input logic [6:0] a);
		k0 = n_st;
		apb(1'b1, radio_bid_pkg::OFS_BIDADDR, {23'h0, s});
		wait_for(n_st, k0 + 1);
		repeat (30 * TK) @(posedge mclk);
		chk("single bid", {1'b1, a}, sq[k0]);
		chk("bid count", k0 + 1, n_st);
	endtask : t_single
	task t_pause(input logic [31:0] cnt, input logic longer);
		apb(1'b1, radio_bid_pkg::OFS_MSGCNT, cnt);
		apb(1'b1, radio_bid_pkg::OFS_PAUSE, 32'd20);
		k0 = n_st;
		send_msg(7'h41);
		send_msg(7'h42);
		chk("pause gap", longer, 32'(tq[k0 + 1] - tq[k0] >= 20 * TK));
	endtask : t_pause
	////////////////////////////////////////////////////////////////////////////////
	// Clock and main sequence
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		{reset_n, psel, penable, pwrite, msg_req, reply_on} = 6'b000001;
		{paddr, pwdata, msg_addr, reply_id, lag} = {12'h0, 32'h0, 7'h0, 8'h5a, 4'h1};
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs();
		t_msg_ok();
		lag <= 4'h6;
		t_fail(1'b1, 3);
		t_fail(1'b0, 1);
		t_bid_dec();
		t_bid(9'd301, 7'h1, 7'h0);
		t_bid(9'd205, 7'h5, 7'h5);
		t_single(9'd100, 7'h0);
		t_single(9'd7, 7'h7);
		t_pause(32'h1, 1'b1);
		t_pause(32'h0, 1'b0);
		complete_run();
	end
endmodule : tb
`default_nettype wire
